// ### design/highpass_path.sv
// Digital highpass filter path feeding the detectors
`timescale 1ns/10ps
`default_nettype none
module highpass_path
  import motion_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sample_valid,
  input wire sample_t sample_in,
  input wire logic [2:0] mode,
  output logic filt_valid,
  output sample_t filt_out
);

  typedef struct packed {
    sample_t held;
    sample_t out;
    logic valid;
  } hp_state_t;

  hp_state_t s;
  hp_state_t next_s;
  logic [3:0] shift;

  // ****************************************
  // Cut-off select: larger shift, lower cut-off
  // ****************************************
  always_comb begin
    unique case (mode)
      3'd1: shift = 4'd4;
      3'd2: shift = 4'd5;
      3'd3: shift = 4'd6;
      3'd4: shift = 4'd7;
      default: shift = 4'd0;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.valid = sample_valid;
    if (sample_valid) begin
      if (mode == 3'd7) begin
        next_s.out.x = sample_in.x - s.held.x;
        next_s.out.y = sample_in.y - s.held.y;
        next_s.out.z = sample_in.z - s.held.z;
      end else if (shift == 4'd0) begin
        next_s.held = sample_in;
        next_s.out = '0;
      end else begin
        next_s.held.x = s.held.x + ((sample_in.x - s.held.x) >>> shift);
        next_s.held.y = s.held.y + ((sample_in.y - s.held.y) >>> shift);
        next_s.held.z = s.held.z + ((sample_in.z - s.held.z) >>> shift);
        next_s.out.x = sample_in.x - s.held.x;
        next_s.out.y = sample_in.y - s.held.y;
        next_s.out.z = sample_in.z - s.held.z;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign filt_valid = s.valid;
  assign filt_out = s.out;

endmodule
`default_nettype wire

// ### design/motion_detector.sv
// Motion and stillness event detector with AXI4-Lite registers
// Contract
// - Any axis magnitude above motion threshold is motion; advances motion count.
// - Motion interrupt when motion count reaches motion duration.
// - Motion count advances on a 1 kHz tick, 1 ms per step.
// - On motion interrupt, record axis and polarity in event status.
// - Both thresholds are 8-bit read/write values.
// - Both durations are 8-bit read/write terminal counts.
// - All three axes below stillness threshold is stillness; advances count.
// - Stillness interrupt when stillness count reaches stillness duration.
// - Stillness interrupts on entry and exit; motion only on detection.
// - Stillness status bit set on entry, cleared on exit.
// - Stillness count advances on a 16 Hz tick, 62.5 ms per step.
// - Detectors use the highpass filtered path, not the data registers.
`timescale 1ns/10ps
`default_nettype none
module motion_detector
  import motion_pkg::*;
#(
  parameter int MOTION_TICK = MOTION_TICK_CYCLES,
  parameter int STILL_TICK = STILL_TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SAMPLE_VALID,
  input wire sample_t SAMPLE,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [31:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic IRQ
);

  typedef struct packed {
    config_t cfg;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [7:0] event_status;
    logic [7:0] motion_count;
    logic [7:0] still_count;
    logic motion_seen;
    logic still_seen;
    logic motion_fired;
    logic still_on;
    logic [6:0] last_dir;
    logic aw_full;
    logic [7:0] aw_idx;
    logic w_full;
    logic [7:0] w_byte;
    logic w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } state_t;

  state_t s;
  state_t next_s;
  logic motion_tick;
  logic still_tick;
  logic filt_valid;
  sample_t filt;
  logic [15:0] ax;
  logic [15:0] ay;
  logic [15:0] az;
  logic hit_x;
  logic hit_y;
  logic hit_z;
  logic is_motion;
  logic is_still;
  logic [6:0] dir;
  logic do_write;
  logic motion_step;
  logic still_step;

  // ****************************************
  // Submodules
  // ****************************************
  tick_divider #(.PERIOD(MOTION_TICK)) u_motion_tick (
    .clock(CLOCK),
    .rst(RST),
    .tick(motion_tick)
  );

  tick_divider #(.PERIOD(STILL_TICK)) u_still_tick (
    .clock(CLOCK),
    .rst(RST),
    .tick(still_tick)
  );

  highpass_path u_hpf (
    .clock(CLOCK),
    .rst(RST),
    .sample_valid(SAMPLE_VALID),
    .sample_in(SAMPLE),
    .mode(s.cfg.hpf_mode),
    .filt_valid(filt_valid),
    .filt_out(filt)
  );

  // ****************************************
  // Sample classification
  // ****************************************
  // Magnitudes from the filtered path only
  always_comb begin
    ax = filt.x[15] ? 16'(-filt.x) : 16'(filt.x);
    ay = filt.y[15] ? 16'(-filt.y) : 16'(filt.y);
    az = filt.z[15] ? 16'(-filt.z) : 16'(filt.z);
    hit_x = ax > {8'h00, s.cfg.motion_threshold};
    hit_y = ay > {8'h00, s.cfg.motion_threshold};
    hit_z = az > {8'h00, s.cfg.motion_threshold};
    is_motion = hit_x | hit_y | hit_z;
    is_still = (ax < {8'h00, s.cfg.stillness_threshold})
      && (ay < {8'h00, s.cfg.stillness_threshold})
      && (az < {8'h00, s.cfg.stillness_threshold});
    // Bits 7..2: X-,X+,Y-,Y+,Z-,Z+
    dir = {hit_x & filt.x[15], hit_x & ~filt.x[15],
      hit_y & filt.y[15], hit_y & ~filt.y[15],
      hit_z & filt.z[15], hit_z & ~filt.z[15], 1'b0};
  end

  assign do_write = s.aw_full && s.w_full && !s.bvalid;
  // A failing sample in the tick cycle wins over the count step
  assign motion_step = motion_tick && s.motion_seen && !s.motion_fired
    && !(filt_valid && !is_motion);
  assign still_step = still_tick && s.still_seen && !s.still_on
    && !(filt_valid && !is_still);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    // Latch qualifying samples until a failing sample clears the latch
    if (filt_valid) begin
      if (is_motion) begin
        next_s.motion_seen = 1'b1;
        next_s.last_dir = dir;
      end else begin
        next_s.motion_count = RESET_BYTE;
        next_s.motion_fired = 1'b0;
        next_s.motion_seen = 1'b0;
      end
      if (is_still) begin
        next_s.still_seen = 1'b1;
      end else begin
        next_s.still_count = RESET_BYTE;
        next_s.still_seen = 1'b0;
      end
    end
    // Motion duration counter on the 1 kHz tick
    if (motion_step) begin
      if (s.motion_count >= s.cfg.motion_duration) begin
        next_s.flags[FLAG_MOTION] = 1'b1;
        next_s.motion_fired = 1'b1;
        next_s.event_status[7:1] = s.last_dir;
      end else begin
        next_s.motion_count = s.motion_count + 8'd1;
      end
    end
    // Stillness duration counter on the 16 Hz tick
    if (still_step) begin
      if (s.still_count >= s.cfg.stillness_duration) begin
        next_s.flags[FLAG_STILL] = 1'b1;
        next_s.still_on = 1'b1;
        next_s.event_status[STAT_STILL] = 1'b1;
      end else begin
        next_s.still_count = s.still_count + 8'd1;
      end
    end
    // Exit from stillness raises a second interrupt
    if (s.still_on && filt_valid && is_motion) begin
      next_s.flags[FLAG_STILL] = 1'b1;
      next_s.still_on = 1'b0;
      next_s.event_status[STAT_STILL] = 1'b0;
    end
    // Write channel capture
    if (AWVALID && AWREADY) begin
      next_s.aw_full = 1'b1;
      next_s.aw_idx = AWADDR[9:2];
    end
    if (WVALID && WREADY) begin
      next_s.w_full = 1'b1;
      next_s.w_byte = WDATA[7:0];
      next_s.w_strb = WSTRB[0];
    end
    if (do_write) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_idx)
        IDX_MOTION_THRESHOLD:
          if (s.w_strb) next_s.cfg.motion_threshold = s.w_byte;
        IDX_MOTION_DURATION:
          if (s.w_strb) next_s.cfg.motion_duration = s.w_byte;
        IDX_STILLNESS_THRESHOLD:
          if (s.w_strb) next_s.cfg.stillness_threshold = s.w_byte;
        IDX_STILLNESS_DURATION:
          if (s.w_strb) next_s.cfg.stillness_duration = s.w_byte;
        IDX_HIGHPASS_FILTER_MODE:
          if (s.w_strb) next_s.cfg.hpf_mode = s.w_byte[2:0];
        IDX_EVENT_MASK:
          if (s.w_strb) next_s.mask = s.w_byte[1:0];
        IDX_EVENT_FLAGS:
          // Set beats clear
          if (s.w_strb) next_s.flags = next_s.flags & ~(s.w_byte[1:0] & ~(
            next_s.flags & ~s.flags));
        IDX_MOTION_EVENT_STATUS: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    // Read channel
    if (ARVALID && ARREADY) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (ARADDR[9:2])
        IDX_MOTION_THRESHOLD: next_s.rdata = {24'h00_0000, s.cfg.motion_threshold};
        IDX_MOTION_DURATION: next_s.rdata = {24'h00_0000, s.cfg.motion_duration};
        IDX_STILLNESS_THRESHOLD:
          next_s.rdata = {24'h00_0000, s.cfg.stillness_threshold};
        IDX_STILLNESS_DURATION:
          next_s.rdata = {24'h00_0000, s.cfg.stillness_duration};
        IDX_HIGHPASS_FILTER_MODE: next_s.rdata = {29'h0000_0000, s.cfg.hpf_mode};
        IDX_EVENT_MASK: next_s.rdata = {30'h0000_0000, s.mask};
        IDX_EVENT_FLAGS: next_s.rdata = {30'h0000_0000, s.flags};
        IDX_MOTION_EVENT_STATUS: next_s.rdata = {24'h00_0000, s.event_status};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    next_s.irq = |(next_s.flags & next_s.mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign AWREADY = !s.aw_full;
  assign WREADY = !s.w_full;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = !s.rvalid;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign IRQ = s.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_motion_count_reset: assert property (
    filt_valid && !is_motion |=> s.motion_count == 8'h00)
    else $error("motion count not cleared");
  a_still_count_reset: assert property (
    filt_valid && !is_still |=> s.still_count == 8'h00)
    else $error("stillness count not cleared");
  a_motion_fire: assert property (
    motion_step
    && s.motion_count >= s.cfg.motion_duration |=> s.flags[FLAG_MOTION])
    else $error("motion flag not set at terminal count");
  a_motion_tick_only: assert property (
    !motion_tick && !(s.bvalid) |=> s.motion_count <= $past(s.motion_count))
    else $error("motion count moved without tick");
  a_motion_dir: assert property (
    $rose(s.motion_fired) |-> s.event_status[7:1] == $past(s.last_dir))
    else $error("direction not recorded");
  a_still_entry: assert property (
    $rose(s.still_on) |-> s.event_status[STAT_STILL] && s.flags[FLAG_STILL])
    else $error("stillness entry not flagged");
  a_still_exit: assert property (
    s.still_on && filt_valid && is_motion
    |=> !s.still_on && s.flags[FLAG_STILL] && !s.event_status[STAT_STILL])
    else $error("stillness exit not flagged");
  a_still_tick_only: assert property (
    !still_tick |=> s.still_count <= $past(s.still_count))
    else $error("stillness count moved without tick");
  a_irq_level: assert property (
    ##1 IRQ == $past(|(next_s.flags & next_s.mask)))
    else $error("interrupt not mask gated");

  c_motion: cover property ($rose(s.flags[FLAG_MOTION]));
  c_still_in: cover property ($rose(s.still_on));
  c_still_out: cover property ($fell(s.still_on));
  c_write: cover property (do_write ##[1:4] BVALID);

endmodule
`default_nettype wire

// ### design/motion_pkg.sv
// Package: register map, field layouts, timing constants and carriers
package motion_pkg;

  // ****************************************
  // Register map
  // ****************************************
  // Printed offsets are not multiples of four: index, byte address = 4*index
  localparam logic [7:0] IDX_MOTION_THRESHOLD = 8'h1F;
  localparam logic [7:0] IDX_MOTION_DURATION = 8'h20;
  localparam logic [7:0] IDX_STILLNESS_THRESHOLD = 8'h21;
  localparam logic [7:0] IDX_STILLNESS_DURATION = 8'h22;
  localparam logic [7:0] IDX_HIGHPASS_FILTER_MODE = 8'h1C;
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h3A;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h38;
  localparam logic [7:0] IDX_MOTION_EVENT_STATUS = 8'h61;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_HPF_MODE = 3'h0;

  // ****************************************
  // Event flag layout
  // ****************************************
  localparam int FLAG_MOTION = 0;
  localparam int FLAG_STILL = 1;

  // Motion event status fields
  localparam int STAT_STILL = 0;
  localparam int STAT_ZPOS = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_HZ = 100_000_000;
  localparam int MOTION_TICK_HZ = 1_000;
  localparam int STILL_TICK_HZ = 16;
  localparam int MOTION_TICK_CYCLES = CLOCK_HZ / MOTION_TICK_HZ;
  localparam int STILL_TICK_CYCLES = CLOCK_HZ / STILL_TICK_HZ;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } sample_t;

  typedef struct packed {
    logic [7:0] motion_threshold;
    logic [7:0] motion_duration;
    logic [7:0] stillness_threshold;
    logic [7:0] stillness_duration;
    logic [2:0] hpf_mode;
  } config_t;

  typedef enum logic [1:0] {
    HPF_RESET = 2'b00,
    HPF_ON = 2'b01,
    HPF_HOLD = 2'b10
  } hpf_state_t;

endpackage

// ### design/tick_divider.sv
// One-cycle enable pulse every PERIOD clocks
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int PERIOD = 100
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick
);

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count >= 32'(PERIOD - 1)) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 32'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule
`default_nettype wire

// ### test/test_motion_detector.sv
// Self-checking testbench for the motion and stillness detector
`timescale 1ns/10ps
`default_nettype none
module test_motion_detector;
  import motion_pkg::*;
  // ****************************************
  // Clock, reset and ports
  // ****************************************
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic SAMPLE_VALID = 1'b0;
  sample_t SAMPLE = '0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] AWADDR = '0, WDATA = '0, ARADDR = '0;
  logic [3:0] WSTRB = 4'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  int n_mismatch = 0;
  int comparisons = 0;
  sample_t cur = '0;
  logic feeding = 1'b0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [7:0] v;
  int n;
  always #5 CLOCK = ~CLOCK;
  motion_detector #(.MOTION_TICK(10), .STILL_TICK(40)) motion_detector_inst (
    .CLOCK(CLOCK), .RST(RST), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE(SAMPLE),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .IRQ(IRQ)
  );
  // Sample stream runs beside the register traffic
  always @(posedge CLOCK) begin
    SAMPLE_VALID <= feeding;
    SAMPLE <= cur;
  end
  // ****************************************
  // Tasks and functions
  // ****************************************
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    n_mismatch++;
    $display("MISMATCH %s expected answer seen none", what);
    end_of_test();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    output logic [1:0] resp);
    int k;
    logic b;
    @(posedge CLOCK);
    AWVALID <= 1'b1;
    AWADDR <= {22'h0, idx, 2'b00};
    WVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= 4'hF;
    BREADY <= 1'b1;
    b = 1'b0;
    for (k = 0; k < 200 && !b; k++) begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) begin
        b = 1'b1;
        resp = BRESP;
        BREADY <= 1'b0;
      end
    end
    if (!b) hang("write response");
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d,
                        output logic [1:0] resp);
    int k;
    logic b;
    @(posedge CLOCK);
    ARVALID <= 1'b1;
    ARADDR <= {22'h0, idx, 2'b00};
    RREADY <= 1'b1;
    b = 1'b0;
    for (k = 0; k < 200 && !b; k++) begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) begin
        b = 1'b1;
        d = RDATA;
        resp = RRESP;
        RREADY <= 1'b0;
      end
    end
    if (!b) hang("read data");
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge CLOCK);
  endtask
  task automatic wait_irq(input int bound, output int used);
    for (used = 0; used < bound && IRQ !== 1'b1; used++) @(posedge CLOCK);
    if (IRQ !== 1'b1) hang("IRQ");
  endtask
  function automatic sample_t one_axis(input int axis, input logic [15:0] s);
    sample_t r;
    r = '0;
    if (axis == 0) r.x = s;
    if (axis == 1) r.y = s;
    if (axis == 2) r.z = s;
    return r;
  endfunction
  function automatic logic [31:0] status_bit(input int axis, input bit neg);
    return 32'h0000_0001 << (7 - 2 * axis - (neg ? 0 : 1));
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h1861));
    cycles(8);
    RST <= 1'b0;
    feeding = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_reg(IDX_MOTION_THRESHOLD + 8'(i), rd, rsp);
      check("config reset", rd, {24'h0, RESET_BYTE});
      v = 8'($urandom);
      wr(IDX_MOTION_THRESHOLD + 8'(i), {24'($urandom), v}, rsp);
      rd_reg(IDX_MOTION_THRESHOLD + 8'(i), rd, rsp);
      check("config readback", rd, {24'h0, v});
      check("config resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    end
    rd_reg(8'h40, rd, rsp);
    check("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    check("unmapped data", rd, 32'h0000_0000);
    wr(8'h40, 32'h0000_00FF, rsp);
    check("unmapped wresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Hold mode on a zero input passes later samples straight through
    wr(IDX_HIGHPASS_FILTER_MODE, 32'h0000_0007, rsp);
    wr(IDX_MOTION_THRESHOLD, 32'h0000_0040, rsp);
    wr(IDX_MOTION_DURATION, 32'h0000_0008, rsp);
    wr(IDX_STILLNESS_THRESHOLD, 32'h0000_0000, rsp);
    wr(IDX_EVENT_FLAGS, 32'h0000_0003, rsp);
    wr(IDX_EVENT_MASK, 32'h0000_0001, rsp);
    // Interrupted run must restart the count
    cur = one_axis(0, 16'h2000);
    cycles(50);
    cur = '0;
    cycles(1);
    cur = one_axis(0, 16'h2000);
    cycles(50);
    check("irq after broken run", {31'h0, IRQ}, 32'h0000_0000);
    wait_irq(60, n);
    check("motion delay", 32'(n + 50 >= 70), 32'h0000_0001);
    check("motion irq", {31'h0, IRQ}, 32'h0000_0001);
    // Mask and write-one-clear
    wr(IDX_EVENT_MASK, 32'h0000_0000, rsp);
    cycles(2);
    check("irq masked", {31'h0, IRQ}, 32'h0000_0000);
    wr(IDX_EVENT_FLAGS, 32'h0000_0002, rsp);
    rd_reg(IDX_EVENT_FLAGS, rd, rsp);
    check("flags kept", rd & 32'h0000_0001, 32'h0000_0001);
    wr(IDX_EVENT_FLAGS, 32'h0000_0001, rsp);
    wr(IDX_EVENT_MASK, 32'h0000_0001, rsp);
    cur = '0;
    cycles(40);
    check("no motion exit irq", {31'h0, IRQ}, 32'h0000_0000);
    // Every axis and polarity, random short durations from 0 to 3
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom_range(0, 3));
      wr(IDX_MOTION_DURATION, {24'h0, v}, rsp);
      cur = one_axis(i / 2, (i % 2) ? 16'hD000 : 16'h3000);
      wait_irq((int'(v) + 4) * 10, n);
      rd_reg(IDX_MOTION_EVENT_STATUS, rd, rsp);
      check("axis status", rd & 32'h0000_00FC, status_bit(i / 2, i % 2));
      check("motion fired", {31'h0, IRQ}, 32'h0000_0001);
      cur = '0;
      cycles(30);
      wr(IDX_EVENT_FLAGS, 32'h0000_0001, rsp);
      cycles(2);
      check("flag cleared", {31'h0, IRQ}, 32'h0000_0000);
    end
    // Stillness entry and exit
    wr(IDX_MOTION_THRESHOLD, 32'h0000_00FF, rsp);
    wr(IDX_STILLNESS_DURATION, 32'h0000_0002, rsp);
    wr(IDX_STILLNESS_THRESHOLD, 32'h0000_0040, rsp);
    wr(IDX_EVENT_MASK, 32'h0000_0002, rsp);
    cur.x = 16'($urandom_range(0, 3));
    cur.y = -16'($urandom_range(0, 3));
    cur.z = 16'($urandom_range(0, 3));
    wait_irq(5 * 40, n);
    check("still irq", {31'h0, IRQ}, 32'h0000_0001);
    rd_reg(IDX_MOTION_EVENT_STATUS, rd, rsp);
    check("still status set", rd & 32'h0000_0001, 32'h0000_0001);
    rd_reg(IDX_EVENT_FLAGS, rd, rsp);
    check("still flag", rd & 32'h0000_0002, 32'h0000_0002);
    check("still dwell", 32'(n >= 40), 32'h0000_0001);
    wr(IDX_EVENT_FLAGS, 32'h0000_0002, rsp);
    cycles(2);
    check("still cleared", {31'h0, IRQ}, 32'h0000_0000);
    cur = one_axis(1, 16'h4000);
    wait_irq(40, n);
    check("exit irq", {31'h0, IRQ}, 32'h0000_0001);
    rd_reg(IDX_MOTION_EVENT_STATUS, rd, rsp);
    check("still status clr", rd & 32'h0000_0001, 32'h0000_0000);
    // Reset mode blocks the detectors from the raw samples
    wr(IDX_HIGHPASS_FILTER_MODE, 32'h0000_0000, rsp);
    wr(IDX_MOTION_THRESHOLD, 32'h0000_0010, rsp);
    wr(IDX_MOTION_DURATION, 32'h0000_0000, rsp);
    wr(IDX_EVENT_FLAGS, 32'h0000_0003, rsp);
    wr(IDX_EVENT_MASK, 32'h0000_0001, rsp);
    cur = one_axis(2, 16'h5000);
    cycles(60);
    check("filtered path", {31'h0, IRQ}, 32'h0000_0000);
    end_of_test();
  end
  initial begin
    #900_000;
    hang("run time");
  end
endmodule
`default_nettype wire
